// file: include/ext_irq_cfg.svh
// offsets, vector addresses and reset values of the external pin interrupt unit
// assumes a wishbone byte address where each register takes one aligned word
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// register index; byte address is four times this
`define PC_MASK_IDX    8'h10
`define MASK_IDX       8'h13
`define SENSE_IDX      8'h14
`define FLAGS_IDX      8'h15
`define PCCTRL_IDX     8'h16
`define PCFLAGS_IDX    8'h17
`define GIE_IDX        8'h18
`define VEC_IDX        8'h19

`define MASK_RST       8'h00
`define PC_MASK_RST    8'h00
`define SENSE_RST      8'h00
`define PCCTRL_RST     8'h00
`define PC_WIDTH       4

// program addresses of the vectors
`define VEC_RESET      10'h000
`define VEC_EXT        10'h001
`define VEC_PC         10'h002
`define VEC_TCAPT      10'h003
`define VEC_TOVF       10'h004
`define VEC_TMA        10'h005
`define VEC_TMB        10'h006
`define VEC_CMP        10'h007
`define VEC_WDOG       10'h008
`define VEC_SUPPLY     10'h009
`define VEC_ADC        10'h00a

`endif

// file: include/ext_irq_pkg.sv
// types of the external pin interrupt unit
// assumes nothing beyond the constants header
`default_nettype none

package ext_irq_pkg;
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'h0,
    SENSE_ANY  = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } sense_t;

  // vector request to the core
  typedef struct packed {
    logic       valid;
    logic [9:0] addr;
  } vec_req_t;

  // request lines from the sources other than this unit
  typedef struct packed {
    logic tcapt;
    logic tovf;
    logic tma;
    logic tmb;
    logic cmp;
    logic wdog;
    logic supply;
    logic adc;
  } other_irq_t;
endpackage

`default_nettype wire

// file: logic/ext_irq_unit.sv
// external pin and pin-change interrupt unit with vector selection
// assumes a classic wishbone master on clk_i; pins arrive asynchronously
// Function
// - every reset cause vectors to address 0x000
// - fixed single-word vector per interrupt source
// - pin activity triggers even when pins drive
// - any enabled pin-change input toggling requests
// - pin changes seen without a running clock
// - sense select: low, change, fall, rise
// - low level requests while pin stays low
// - edges recognised only with running clock
// - low level seen without a clock
// - vanished wake level wakes without interrupt
// - pin sampled; pulses over one clock caught
// - external vector needs mask bit and global enable
// - edge or change sets external flag
// - flag cleared on entry or write one
// - external flag stays zero in level mode
// - pin-change vector needs enable and global enable
// - pin-change flag set, cleared entry or write-one
// - pin-change mask at 0x10, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"

module ext_irq_unit
  import ext_irq_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // classic wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [9:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // pins, asynchronous to clk_i
  input  wire logic               ext_irq_pin_i,
  input  wire logic [3:0]         pin_change_inputs_i,
  // sleep and reset causes
  input  wire logic               io_clk_run_i,
  input  wire logic               reset_cause_i,
  // core side
  input  wire logic               status_gie_i,
  input  wire logic               vec_taken_i,
  input  wire other_irq_t         other_irq_i,
  output vec_req_t                vec_req_o,
  output logic                    wake_o
);

  logic [7:0]  mask_q;
  logic [7:0]  sense_q;
  logic [7:0]  pcctrl_q;
  logic [7:0]  pc_mask_q;
  logic        ext_flag_q;
  logic        pc_flag_q;
  logic [1:0]  ext_sync_q;
  logic [3:0]  pc_s1_q;
  logic [3:0]  pc_s2_q;
  logic        ext_prev_q;
  logic [3:0]  pc_prev_q;
  logic        ack_q;
  logic [31:0] dat_q;
  vec_req_t    vec_q;
  logic        rst_seen_q;

  function automatic logic reg_hit(input logic [9:0] a,
                                   input logic [7:0] idx);
    reg_hit = (a[9:2] == idx);
  endfunction

  wire logic   req    = cyc_i && stb_i && !ack_q;
  wire logic   wr_req = req && we_i && sel_i[0];
  wire sense_t sense  = sense_t'(sense_q[1:0]);
  wire logic   ext_s  = ext_sync_q[1];

  // two-flop synchronisers, pin level read whatever its direction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_sync_q <= 2'h3;
      pc_s1_q    <= 4'h0;
      pc_s2_q    <= 4'h0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], ext_irq_pin_i};
      pc_s1_q    <= pin_change_inputs_i;
      pc_s2_q    <= pc_s1_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_prev_q <= 1'b1;
      pc_prev_q  <= 4'h0;
    end
    else
    begin
      ext_prev_q <= ext_s;
      pc_prev_q  <= pc_s2_q;
    end
  end

  // edge detection needs the io clock to be running
  logic ext_edge_ev;
  always_comb
  begin
    ext_edge_ev = 1'b0;
    case (sense)
      SENSE_ANY:  ext_edge_ev = ext_s ^ ext_prev_q;
      SENSE_FALL: ext_edge_ev = ext_prev_q && !ext_s;
      SENSE_RISE: ext_edge_ev = !ext_prev_q && ext_s;
      default:    ext_edge_ev = 1'b0;
    endcase
    ext_edge_ev = ext_edge_ev && io_clk_run_i;
  end

  wire logic level_mode = (sense == SENSE_LOW);
  wire logic level_req  = level_mode && !ext_s;
  wire logic pc_ev = |((pc_s2_q ^ pc_prev_q) & pc_mask_q[3:0]);

  // clockless wake path: raw low level or raw change against last sample
  wire logic pc_raw_ch =
    |((pin_change_inputs_i ^ pc_prev_q) & pc_mask_q[3:0]);
  assign wake_o = (level_mode && mask_q[0] && !ext_irq_pin_i)
                || (pcctrl_q[0] && pc_raw_ch);

  wire logic ext_en = mask_q[0] && status_gie_i;
  wire logic pc_en  = pcctrl_q[0] && status_gie_i;
  // level request reads the live synchronised level, so a level gone
  // before wake-up completes yields no vector
  wire logic ext_pend = ext_en && (level_mode ? level_req : ext_flag_q);
  wire logic pc_pend  = pc_en && pc_flag_q;

  wire logic ent_ext = vec_taken_i && vec_q.valid &&
                       (vec_q.addr == `VEC_EXT);
  wire logic ent_pc  = vec_taken_i && vec_q.valid &&
                       (vec_q.addr == `VEC_PC);

  wire logic w_flags   = wr_req && reg_hit(adr_i, `FLAGS_IDX);
  wire logic w_pcflags = wr_req && reg_hit(adr_i, `PCFLAGS_IDX);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ext_flag_q <= 1'b0;
    else if (level_mode)
      ext_flag_q <= 1'b0;
    else if (ext_edge_ev)
      ext_flag_q <= 1'b1;
    else if (ent_ext || (w_flags && dat_i[0]))
      ext_flag_q <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pc_flag_q <= 1'b0;
    else if (pc_ev)
      pc_flag_q <= 1'b1;
    else if (ent_pc || (w_pcflags && dat_i[0]))
      pc_flag_q <= 1'b0;
  end

  // vector selection, lowest number wins
  logic [9:0] vaddr;
  logic       vvalid;
  always_comb
  begin
    vvalid = 1'b1;
    vaddr  = `VEC_RESET;
    if (rst_seen_q)
      vaddr = `VEC_RESET;
    else if (ext_pend)
      vaddr = `VEC_EXT;
    else if (pc_pend)
      vaddr = `VEC_PC;
    else if (other_irq_i.tcapt)
      vaddr = `VEC_TCAPT;
    else if (other_irq_i.tovf)
      vaddr = `VEC_TOVF;
    else if (other_irq_i.tma)
      vaddr = `VEC_TMA;
    else if (other_irq_i.tmb)
      vaddr = `VEC_TMB;
    else if (status_gie_i && other_irq_i.cmp)
      vaddr = `VEC_CMP;
    else if (status_gie_i && other_irq_i.wdog)
      vaddr = `VEC_WDOG;
    else if (status_gie_i && other_irq_i.supply)
      vaddr = `VEC_SUPPLY;
    else if (status_gie_i && other_irq_i.adc)
      vaddr = `VEC_ADC;
    else
      vvalid = 1'b0;
    if (!rst_seen_q && !status_gie_i)
      vvalid = 1'b0;
  end

  // reset cause request held until the core takes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rst_seen_q <= 1'b1;
    else if (reset_cause_i)
      rst_seen_q <= 1'b1;
    else if (vec_taken_i && vec_q.valid && vec_q.addr == `VEC_RESET)
      rst_seen_q <= 1'b0;
  end

  // registered vector; cleared a cycle after a take to avoid a double entry
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vec_q <= '0;
    else if (vec_taken_i)
      vec_q <= '0;
    else
      vec_q <= '{valid: vvalid, addr: vaddr};
  end
  assign vec_req_o = vec_q;

  // register writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q   <= `MASK_RST;
      sense_q  <= `SENSE_RST;
      pcctrl_q <= `PCCTRL_RST;
      pc_mask_q <= `PC_MASK_RST;
    end
    else if (wr_req)
    begin
      if (reg_hit(adr_i, `MASK_IDX))
        mask_q <= {7'h00, dat_i[0]};
      if (reg_hit(adr_i, `SENSE_IDX))
        sense_q <= {6'h00, dat_i[1:0]};
      if (reg_hit(adr_i, `PCCTRL_IDX))
        pcctrl_q <= {7'h00, dat_i[0]};
      if (reg_hit(adr_i, `PC_MASK_IDX))
        pc_mask_q <= {4'h0, dat_i[3:0]};
    end
  end

  // read data, one cycle answer; unmapped reads zero
  logic [7:0] rd;
  always_comb
  begin
    rd = 8'h00;
    case (adr_i[9:2])
      `MASK_IDX:    rd = mask_q;
      `SENSE_IDX:   rd = sense_q;
      `FLAGS_IDX:   rd = {7'h00, ext_flag_q};
      `PCCTRL_IDX:  rd = pcctrl_q;
      `PCFLAGS_IDX: rd = {7'h00, pc_flag_q};
      `PC_MASK_IDX: rd = pc_mask_q;
      `GIE_IDX:     rd = {7'h00, status_gie_i};
      `VEC_IDX:     rd = {vec_q.valid, 3'h0, vec_q.addr[3:0]};
      default:      rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end
    else
    begin
      ack_q <= req;
      dat_q <= req ? {24'h0, rd} : 32'h0;
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // flag set by an edge is never lost to a same-cycle write-one
  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
    (ext_edge_ev && !level_mode) |=> ext_flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("edge set lost");

  property p_level_flag;
    @(posedge clk_i) disable iff (rst_i)
    level_mode ##1 level_mode |-> !ext_flag_q;
  endproperty
  a_level_flag: assert property (p_level_flag)
    else $error("flag set in level mode");

  property p_ext_gate;
    @(posedge clk_i) disable iff (rst_i)
    (vec_q.valid && vec_q.addr == `VEC_EXT) |->
      $past(mask_q[0]) && $past(status_gie_i);
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("ext vector without enables");

  property p_pc_gate;
    @(posedge clk_i) disable iff (rst_i)
    (vec_q.valid && vec_q.addr == `VEC_PC) |->
      $past(pcctrl_q[0]) && $past(status_gie_i);
  endproperty
  a_pc_gate: assert property (p_pc_gate)
    else $error("pc vector without enables");

  property p_pc_set;
    @(posedge clk_i) disable iff (rst_i)
    pc_ev |=> pc_flag_q;
  endproperty
  a_pc_set: assert property (p_pc_set)
    else $error("pin change flag not set");

  property p_prio;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_seen_q && ext_pend && !vec_taken_i) |=> vec_q.addr == `VEC_EXT;
  endproperty
  a_prio: assert property (p_prio)
    else $error("ext not first");

  property p_level_req;
    @(posedge clk_i) disable iff (rst_i)
    (level_mode && mask_q[0] && status_gie_i && !ext_s && !rst_seen_q
      && !vec_taken_i) |=> vec_q.valid;
  endproperty
  a_level_req: assert property (p_level_req)
    else $error("level request dropped");

  property p_reset_vec;
    @(posedge clk_i) disable iff (rst_i)
    (reset_cause_i && !vec_taken_i) |=> ##1
      ($past(vec_taken_i) || (vec_q.valid && vec_q.addr == `VEC_RESET));
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector missing");

  property p_fall;
    @(posedge clk_i) disable iff (rst_i)
    (sense == SENSE_FALL && io_clk_run_i && ext_prev_q && !ext_s)
      |=> ext_flag_q;
  endproperty
  a_fall: assert property (p_fall)
    else $error("falling edge missed");

  property p_rise;
    @(posedge clk_i) disable iff (rst_i)
    (sense == SENSE_RISE && io_clk_run_i && !ext_prev_q && ext_s)
      |=> ext_flag_q;
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge missed");

  // a stopped io clock must never let an edge reach the flag
  property p_edge_gate;
    @(posedge clk_i) disable iff (rst_i)
    (!io_clk_run_i && !ext_flag_q) |=> !ext_flag_q;
  endproperty
  a_edge_gate: assert property (p_edge_gate)
    else $error("edge seen without io clock");

  property p_w1c;
    @(posedge clk_i) disable iff (rst_i)
    (w_flags && dat_i[0] && !ext_edge_ev) |=> !ext_flag_q;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

endmodule

`default_nettype wire

// file: sim/core_model.sv
// core side model: takes the offered vector on request
// assumes vec_req_o of the unit, same clock
`timescale 1ns/1ps
`default_nettype none

module core_model
  import ext_irq_pkg::*;
(
  // clock
  input  wire logic     clk_i,
  // bench control and unit side
  input  wire logic     take_i,
  input  wire vec_req_t vec_req_i,
  output logic          vec_taken_o
);
  // one-cycle pulse, never back to back, only on a shown request
  always_ff @(posedge clk_i)
  begin
    vec_taken_o <= take_i && vec_req_i.valid && !vec_taken_o;
  end
endmodule

`default_nettype wire

// file: sim/tb_top.sv
// bench of the external pin interrupt unit
// assumes the unit answers bus cycles and shows vectors as noted
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ext_irq_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        pin = 1'b1;
  logic [3:0]  pc = 4'h0;
  logic        take = 1'b0;
  logic        gie = 1'b1;
  logic        ioclk = 1'b1;
  logic        rcause = 1'b0;
  logic        wake;
  logic        taken;
  other_irq_t  other = '0;
  vec_req_t    vreq;
  logic [31:0] q;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #2.5 clk = ~clk;

  ext_irq_unit ext_irq_unit_i (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .ext_irq_pin_i(pin), .pin_change_inputs_i(pc), .io_clk_run_i(ioclk),
    .reset_cause_i(rcause), .status_gie_i(gie), .vec_taken_i(taken),
    .other_irq_i(other), .vec_req_o(vreq), .wake_o(wake));

  core_model core_model_i (
    .clk_i(clk), .take_i(take), .vec_req_i(vreq), .vec_taken_o(taken));

  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle, entered just after a rising edge; ack and read data
  // taken at the rising edge where ack is high, released only then
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t no ack", $time);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, e});
  endtask

  // waits for a shown vector, checks it, lets the core take it
  task automatic take_vec(input logic [9:0] a);
    int n;
    n = 0;
    @(negedge clk);
    while (vreq.valid !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk({21'h0, vreq.valid, vreq.addr}, {21'h0, 1'b1, a});
    @(posedge clk);
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // wake is combinational, so it is judged half a cycle after stimulus
  task automatic chk_wake(input logic e);
    @(negedge clk);
    chk({31'h0, wake}, {31'h0, e});
    @(posedge clk);
  endtask

  task automatic t_regs();
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h30, 8'h00);
    wb(1'b1, 8'h30, 8'hff, q);
    rd_chk(8'h30, 8'h00);
  endtask

  // falling, rising and any-change sensing, flag set and cleared
  task automatic t_edges();
    wb(1'b1, 8'h14, 8'h02, q);
    wb(1'b1, 8'h13, 8'h01, q);
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(8'h15, 8'h01);
    take_vec(10'h001);
    rd_chk(8'h15, 8'h00);
    wb(1'b1, 8'h14, 8'h03, q);
    pin <= 1'b1;
    take_vec(10'h001);
    wb(1'b1, 8'h14, 8'h01, q);
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(8'h15, 8'h01);
    wb(1'b1, 8'h15, 8'h01, q);
    rd_chk(8'h15, 8'h00);
  endtask

  // low level requests and wakes while held; flag stays clear
  task automatic t_level();
    wb(1'b1, 8'h14, 8'h00, q);
    chk_wake(1'b1);
    take_vec(10'h001);
    take_vec(10'h001);
    rd_chk(8'h15, 8'h00);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, vreq.valid}, 32'h0);
    chk_wake(1'b0);
    wb(1'b1, 8'h13, 8'h00, q);
  endtask

  // pin change, then lower vector number wins over timer capture
  task automatic t_change();
    wb(1'b1, 8'h10, 8'h02, q);
    wb(1'b1, 8'h16, 8'h01, q);
    pc <= 4'h1;
    chk_wake(1'b0);
    repeat (8) @(posedge clk);
    chk({31'h0, vreq.valid}, 32'h0);
    pc <= 4'h3;
    chk_wake(1'b1);
    take_vec(10'h002);
    other.tcapt <= 1'b1;
    pc <= 4'h1;
    repeat (6) @(posedge clk);
    take_vec(10'h002);
    take_vec(10'h003);
    other.tcapt <= 1'b0;
  endtask

  // global enable gating, stopped io clock, reset cause
  task automatic t_gates();
    gie <= 1'b0;
    wb(1'b1, 8'h14, 8'h02, q);
    wb(1'b1, 8'h13, 8'h01, q);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk({31'h0, vreq.valid}, 32'h0);
    rd_chk(8'h15, 8'h01);
    gie <= 1'b1;
    take_vec(10'h001);
    ioclk <= 1'b0;
    wb(1'b1, 8'h14, 8'h03, q);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(8'h15, 8'h00);
    ioclk <= 1'b1;
    rcause <= 1'b1;
    @(posedge clk);
    rcause <= 1'b0;
    take_vec(10'h000);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    take_vec(10'h000);
    t_regs();
    t_edges();
    t_level();
    t_change();
    t_gates();
    complete_run();
  end
endmodule

`default_nettype wire
